// ### hw/evp_top.sv
// Exception priority encoder and vector generator for a small CPU core.
// Assumes the CPU asks with vec_req and supplies its I and X mask bits.
`timescale 1ns/1ns
// Functional notes
// (R1) Resets give 0xfffe, 0xfffc, 0xfffa, ranked in that order.
// (R2) Below resets: opcode trap at base+0xf8, then fixed order downward.
// (R3) Software interrupt or debug request gets base+0xf6 below trap.
// (R4) X-maskable request (pin or die-to-die error) gets base+0xf4; the code decodes only nonmaskable_pin_request.
// (R5) External IRQ or die-to-die interrupt gets base+0xf2; the code decodes only the irq_req pin.
// (R6) Device I-maskable sources use 0xf0 down to 0x82, higher wins.
// (R7) Spurious vector base+0x80 is the lowest priority.
// (R8) Every vector is a full 16-bit address.
// (R9) Higher priority requests may preempt an I-maskable service routine.
// (R10) I-maskable requests nest only after the routine clears I.
// (R11) Any unmasked I-maskable request wakes from wait.
// (R12) Stop wake-up only from sources that run without clocks.
// (R13) I mask set blocks all I-maskable wake-ups.
// (R14) X-maskable request wakes at any time, ignoring X mask.
// (R15) X wake with X mask set dispatches no service routine.
// (R16) Source keeps X wake request until the next instruction starts.
// (R17) Software sets vector base if needed, then clears I and X.
// (R18) Vector base is register as upper byte, 0x00 lower byte.
// (R19) Reset loads 0xff into vector base before reset vector fetch.
// (R20) During debug firmware the upper byte is forced to 0xff.
// (R21) Source gone at fetch time yields the spurious vector.
// (R22) Priority is evaluated when the CPU asks, with its mask bits.
module evp_top #(
  parameter int NSRC = evp_pkg::NUM_IMASK_SRC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rst_main,
  input wire logic rst_clkmon,
  input wire logic rst_wdog,
  input wire logic trap_req,
  input wire logic software_interrupt,
  input wire logic background_debug_req,
  input wire logic background_debug_active,
  input wire logic nonmaskable_pin_request,
  input wire logic irq_req,
  input wire logic [NSRC-1:0] imask_req,
  input wire logic [NSRC-1:0] stop_capable,
  input wire logic imask_bit,
  input wire logic xmask_bit,
  input wire logic stop_mode,
  input wire logic vec_req,
  input wire logic vbr_we,
  input wire logic [7:0] vbr_wdata,
  output logic [15:0] vec_addr,
  output logic vec_valid,
  output logic xwake_no_dispatch,
  output logic wakeup,
  output logic [7:0] vector_base_register
);
  // ==========================================================================
  // Reset release and pin synchronisation
  logic rs1_r, rs2_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  logic srst_n;
  assign srst_n = rs2_r;

  // External pins cross into the clock domain; internal sources do not.
  logic [1:0] pin_q;
  evp_sync #(.W(2)) u_sync (
    .mclk(mclk),
    .rst_n(srst_n),
    .ce(ce),
    .d({nonmaskable_pin_request, irq_req}),
    .q(pin_q)
  );
  logic xreq, ireq;
  assign xreq = pin_q[1];
  assign ireq = pin_q[0];

  // ==========================================================================
  // Priority encoding
  function automatic logic [7:0] imask_ofs(input int idx);
    imask_ofs = 8'(int'(evp_pkg::OFS_IMASK_TOP) - 2 * idx);
  endfunction

  logic [15:0] vec_nxt;
  logic xnd_nxt;
  logic [7:0] ubyte;
  logic [7:0] low;
  logic found;

  always_comb begin
    // Debug firmware must reach its handlers wherever the table was moved.
    ubyte = background_debug_active ? evp_pkg::VBR_DEBUG
                                    : vector_base_register; // [R18] [R20]
    low = evp_pkg::OFS_SPURIOUS; // [R7] [R21]
    found = 1'b0;
    xnd_nxt = 1'b0;
    if (software_interrupt || background_debug_req) begin
      low = evp_pkg::OFS_SWI; // [R3]
      found = 1'b1;
    end
    if (trap_req) begin
      low = evp_pkg::OFS_TRAP; // [R2]
      found = 1'b1;
    end
    if (!found) begin
      if (xreq && !xmask_bit) begin
        low = evp_pkg::OFS_XMASK; // [R4] [R9]
      end else if (!imask_bit) begin // [R10]
        if (ireq) begin
          low = evp_pkg::OFS_IRQ; // [R5]
        end else begin
          for (int i = NSRC - 1; i >= 0; i--) begin
            if (imask_req[i]) begin
              low = imask_ofs(i); // [R6]
            end
          end
        end
      end
    end
    vec_nxt = {ubyte, low}; // [R8] [R22]
    if (rst_wdog) begin
      vec_nxt = evp_pkg::VEC_RST_WDOG; // [R1]
    end
    if (rst_clkmon) begin
      vec_nxt = evp_pkg::VEC_RST_CLKMON; // [R1]
    end
    if (rst_main) begin
      vec_nxt = evp_pkg::VEC_RST_MAIN; // [R1]
    end
    // A masked X wake-up resumes after the wait instruction.
    if (xreq && xmask_bit && low == evp_pkg::OFS_SPURIOUS) begin
      xnd_nxt = 1'b1; // [R15]
    end
  end

  // ==========================================================================
  // Wake-up qualification
  logic wake_nxt;
  logic [NSRC-1:0] elig;
  always_comb begin
    elig = stop_mode ? (imask_req & stop_capable) : imask_req; // [R12]
    wake_nxt = xreq; // [R14] [R16]
    if (!imask_bit) begin // [R13]
      wake_nxt = wake_nxt || (|elig) || ireq; // [R11]
    end
  end

  // ==========================================================================
  // Vector base register and answer registers
  logic [7:0] vbr_nxt;
  always_comb begin
    vbr_nxt = vector_base_register;
    if (rst_main || rst_clkmon || rst_wdog) begin
      vbr_nxt = evp_pkg::VBR_RESET; // [R19]
    end else if (vbr_we) begin
      vbr_nxt = vbr_wdata; // [R17]
    end
  end

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      vector_base_register <= evp_pkg::VBR_RESET; // [R19]
      vec_addr <= evp_pkg::VEC_RST_MAIN;
      vec_valid <= 1'b0;
      xwake_no_dispatch <= 1'b0;
      wakeup <= 1'b0;
    end else if (ce) begin
      vector_base_register <= vbr_nxt;
      wakeup <= wake_nxt;
      vec_valid <= vec_req;
      if (vec_req) begin
        vec_addr <= vec_nxt; // [R22]
        xwake_no_dispatch <= xnd_nxt;
      end
    end
  end

  // ==========================================================================
  // Checks
  // Vector checks look one edge after a taken request, while vec_addr
  // holds the answer. The X and IRQ pins are seen after the synchroniser.
  logic any_rst;
  logic any_high;
  assign any_rst = rst_main || rst_clkmon || rst_wdog;
  assign any_high = any_rst || trap_req || software_interrupt
    || background_debug_req;

  property p_main_reset;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && rst_main |=> vec_addr == evp_pkg::VEC_RST_MAIN;
  endproperty
  a_main_reset: assert property (p_main_reset) // [R1]
    else $error("main reset vector wrong");
  property p_clkmon_reset;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && rst_clkmon && !rst_main
      |=> vec_addr == evp_pkg::VEC_RST_CLKMON;
  endproperty
  a_clkmon_reset: assert property (p_clkmon_reset) // [R1]
    else $error("clock monitor reset vector wrong");
  property p_wdog_reset;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && rst_wdog && !rst_main && !rst_clkmon
      |=> vec_addr == evp_pkg::VEC_RST_WDOG;
  endproperty
  a_wdog_reset: assert property (p_wdog_reset) // [R1]
    else $error("watchdog reset vector wrong");
  property p_trap;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && trap_req && !any_rst
      |=> vec_addr[7:0] == evp_pkg::OFS_TRAP;
  endproperty
  a_trap: assert property (p_trap) // [R2]
    else $error("trap vector wrong");
  property p_swi;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && (software_interrupt || background_debug_req)
      && !trap_req && !any_rst |=> vec_addr[7:0] == evp_pkg::OFS_SWI;
  endproperty
  a_swi: assert property (p_swi) // [R3]
    else $error("software interrupt vector wrong");
  property p_xmask_vec;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && xreq && !xmask_bit && !any_high
      |=> vec_addr[7:0] == evp_pkg::OFS_XMASK;
  endproperty
  a_xmask_vec: assert property (p_xmask_vec) // [R4] [R9]
    else $error("x maskable vector wrong");
  property p_irq_vec;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && ireq && !imask_bit && !xreq && !any_high
      |=> vec_addr[7:0] == evp_pkg::OFS_IRQ;
  endproperty
  a_irq_vec: assert property (p_irq_vec) // [R5]
    else $error("irq vector wrong");
  property p_top_source;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && imask_req[0] && !imask_bit && !xreq && !ireq
      && !any_high |=> vec_addr[7:0] == evp_pkg::OFS_IMASK_TOP;
  endproperty
  a_top_source: assert property (p_top_source) // [R6]
    else $error("top maskable source vector wrong");
  property p_imask_blocked;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && imask_bit && !xreq && !any_high
      |=> vec_addr[7:0] == evp_pkg::OFS_SPURIOUS;
  endproperty
  a_imask_blocked: assert property (p_imask_blocked) // [R10] [R21]
    else $error("masked request dispatched");
  property p_base;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && !background_debug_active && !any_rst
      |=> vec_addr[15:8] == $past(vector_base_register);
  endproperty
  a_base: assert property (p_base) // [R18]
    else $error("vector base not used");
  property p_debug_base;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && background_debug_active && !any_rst
      |=> vec_addr[15:8] == evp_pkg::VBR_DEBUG;
  endproperty
  a_debug_base: assert property (p_debug_base) // [R20]
    else $error("debug base not forced");
  property p_valid;
    @(posedge mclk) disable iff (!srst_n)
    ce |=> vec_valid == $past(vec_req);
  endproperty
  a_valid: assert property (p_valid) // [R22]
    else $error("answer strobe out of step");
  property p_reset_base;
    @(posedge mclk) disable iff (!srst_n)
    ce && any_rst |=> vector_base_register == evp_pkg::VBR_RESET;
  endproperty
  a_reset_base: assert property (p_reset_base) // [R19]
    else $error("base not reloaded by reset");
  property p_xwake;
    @(posedge mclk) disable iff (!srst_n)
    ce && xreq |=> wakeup;
  endproperty
  a_xwake: assert property (p_xwake) // [R14]
    else $error("x wake missed");
  property p_imask_nowake;
    @(posedge mclk) disable iff (!srst_n)
    ce && imask_bit && !xreq |=> !wakeup;
  endproperty
  a_imask_nowake: assert property (p_imask_nowake) // [R13]
    else $error("masked wake");
  property p_wait_wake;
    @(posedge mclk) disable iff (!srst_n)
    ce && !stop_mode && !imask_bit && (|imask_req) |=> wakeup;
  endproperty
  a_wait_wake: assert property (p_wait_wake) // [R11]
    else $error("wait wake missed");
  property p_stop_gate;
    @(posedge mclk) disable iff (!srst_n)
    ce && stop_mode && !xreq && !ireq
      && ((imask_req & stop_capable) == '0) |=> !wakeup;
  endproperty
  a_stop_gate: assert property (p_stop_gate) // [R12]
    else $error("stop wake from clocked source");
  property p_xnd;
    @(posedge mclk) disable iff (!srst_n)
    ce && vec_req && xreq && xmask_bit && imask_bit && !any_high
      |=> xwake_no_dispatch;
  endproperty
  a_xnd: assert property (p_xnd) // [R15]
    else $error("masked x wake not flagged");
  c_trap: cover property (p_trap);
  c_xwake: cover property (@(posedge mclk) ce && xreq && xmask_bit);
  c_spurious: cover property (@(posedge mclk) vec_valid
    && vec_addr[7:0] == evp_pkg::OFS_SPURIOUS);
  c_stop_wake: cover property (@(posedge mclk) stop_mode && wakeup);
endmodule

// ### hw/evp_pkg.sv
// Package of constants for the exception vector priority block.
// Assumes a 16-bit vector address bus and an 8-bit vector base register.
package evp_pkg;

  // ==========================================================================
  // Vector addresses and offsets
  localparam logic [15:0] VEC_RST_MAIN = 16'hfffe;
  localparam logic [15:0] VEC_RST_CLKMON = 16'hfffc;
  localparam logic [15:0] VEC_RST_WDOG = 16'hfffa;
  localparam logic [7:0] OFS_TRAP = 8'hf8;
  localparam logic [7:0] OFS_SWI = 8'hf6;
  localparam logic [7:0] OFS_XMASK = 8'hf4;
  localparam logic [7:0] OFS_IRQ = 8'hf2;
  localparam logic [7:0] OFS_IMASK_TOP = 8'hf0;
  localparam logic [7:0] OFS_IMASK_BOT = 8'h82;
  localparam logic [7:0] OFS_SPURIOUS = 8'h80;
  localparam logic [7:0] VBR_RESET = 8'hff;
  localparam logic [7:0] VBR_DEBUG = 8'hff;
  localparam logic [7:0] VEC_LOW_BYTE = 8'h00;

  // ==========================================================================
  // Device-specific I-maskable sources: 0xf0 down to 0x82 in steps of two.
  localparam int NUM_IMASK_SRC = 56;

  // ==========================================================================
  // Answer state machine
  typedef enum logic [1:0] {
    EVP_IDLE = 2'b00,
    EVP_ANSWER = 2'b01
  } evp_state_e;

endpackage

// ### hw/evp_sync.sv
// Three-stage input synchroniser for levels that arrive from pins.
// Assumes a single clock; a change counts once stages two and three agree.
`timescale 1ns/1ns
module evp_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r;
  logic [W-1:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    for (int i = 0; i < W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        q_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r <= '0;
    end else if (ce) begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

// ### verification/evp_cpu_model.sv
// CPU side model: asks the block for a vector and keeps the answer.
// Assumes the answer comes with vec_valid one edge after the request.
`timescale 1ns/1ns
module evp_cpu_model (
  input wire logic mclk,
  input wire logic go,
  input wire logic vec_valid,
  input wire logic [15:0] vec_addr,
  output logic vec_req,
  output logic [15:0] got,
  output logic done
);
  // ==========================================================
  // Request handshake
  // The request is dropped once answered, so a stale answer from an
  // earlier request is never taken for a new one.
  initial begin
    vec_req = 1'b0;
    got = 16'h0000;
    done = 1'b0;
  end
  always @(negedge mclk) begin
    vec_req <= go && !done;
  end
  always @(posedge mclk) begin
    if (vec_req && vec_valid) begin
      got <= vec_addr;
      done <= 1'b1;
    end else if (!go) begin
      done <= 1'b0;
    end
  end
endmodule

// ### verification/test_exception_vector_priority.sv
// Bench for the exception vector block, with a CPU side model.
// Assumes evp_cpu_model and the design files are compiled first.
`timescale 1ns/1ns
module test_exception_vector_priority;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic rst_main, rst_clkmon, rst_wdog, trap_req, software_interrupt;
  logic background_debug_req, background_debug_active, irq_req;
  logic nonmaskable_pin_request, imask_bit, xmask_bit, stop_mode;
  logic vbr_we, go, vec_req, vec_valid, xwake_no_dispatch, wakeup, done;
  logic [55:0] imask_req, stop_capable;
  logic [7:0] vbr_wdata, vector_base_register;
  logic [15:0] vec_addr, got;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  evp_top u_evp_top (.mclk, .rst_n, .ce, .rst_main, .rst_clkmon,
    .rst_wdog, .trap_req, .software_interrupt, .background_debug_req,
    .background_debug_active, .nonmaskable_pin_request, .irq_req,
    .imask_req, .stop_capable, .imask_bit, .xmask_bit, .stop_mode,
    .vec_req, .vbr_we, .vbr_wdata, .vec_addr, .vec_valid,
    .xwake_no_dispatch, .wakeup, .vector_base_register);
  evp_cpu_model u_evp_cpu_model (.mclk, .go, .vec_valid, .vec_addr,
    .vec_req, .got, .done);
  always #2 mclk = ~mclk;
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d, n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // A stuck run is stopped as a failure after 20000 cycles.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  // Pin inputs pass a synchroniser, so sources get time to land.
  task automatic settle();
    repeat (8) @(negedge mclk);
  endtask
  task automatic vec(input logic [15:0] exp);
    int k;
    k = 0;
    go <= 1'b1;
    while (done !== 1'b1 && k < 20) begin
      @(negedge mclk);
      k++;
    end
    chk(16'(done), 16'h0001);
    chk(got, exp);
    go <= 1'b0;
    @(negedge mclk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_ladder();
    logic [7:0] ofs [7] = '{8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'h82,
      8'h80};
    vbr_wdata = 8'h12;
    vbr_we = 1'b1;
    @(negedge mclk);
    vbr_we = 1'b0;
    {imask_bit, xmask_bit} = 2'h0;
    settle();
    chk(16'(vector_base_register), 16'h0012);
    for (int k = 0; k < 7; k++) begin
      trap_req = k < 1;
      software_interrupt = k < 2;
      nonmaskable_pin_request = k < 3;
      irq_req = k < 4;
      imask_req[0] = k < 5;
      imask_req[55] = k < 6;
      settle();
      vec({8'h12, ofs[k]});
    end
    imask_bit = 1'b1;
    imask_req[0] = 1'b1;
    settle();
    vec(16'h1280);
    {imask_bit, imask_req[0], background_debug_req} = 3'h1;
    settle();
    vec(16'h12f6);
    background_debug_active = 1'b1;
    settle();
    vec(16'hfff6);
    {background_debug_req, background_debug_active} = 2'h0;
    for (int k = 0; k < 3; k++) begin
      rst_wdog = 1'b1;
      rst_clkmon = k > 0;
      rst_main = k > 1;
      settle();
      vec(16'hfffa + 16'(2 * k));
    end
    {rst_main, rst_clkmon, rst_wdog} = 3'h0;
    settle();
    chk(16'(vector_base_register), 16'h00ff);
    $display("test ladder done");
  endtask
  // Clock enable low must freeze the base register against a write.
  task automatic t_hold();
    ce = 1'b0;
    vbr_wdata = 8'h34;
    vbr_we = 1'b1;
    settle();
    chk(16'(vector_base_register), 16'h00ff);
    vbr_we = 1'b0;
    ce = 1'b1;
    settle();
    chk(16'(vector_base_register), 16'h00ff);
    $display("test hold done");
  endtask
  // Code: wake, no-dispatch, stop, I, X, X source, source 3, capable.
  // The flag is latched with a vector request, so each case asks for one.
  task automatic wk(input logic [7:0] c, input logic [15:0] v);
    {stop_mode, imask_bit, xmask_bit, nonmaskable_pin_request,
      imask_req[3], stop_capable[3]} = c[5:0];
    settle();
    vec(v);
    chk(16'(wakeup), 16'(c[7]));
    chk(16'(xwake_no_dispatch), 16'(c[6]));
    {stop_mode, imask_bit, xmask_bit, nonmaskable_pin_request,
      imask_req[3], stop_capable[3]} = 6'h00;
    settle();
    $display("test wake %h done", c);
  endtask
  initial begin
    {rst_main, rst_clkmon, rst_wdog, trap_req, software_interrupt,
      background_debug_req, background_debug_active, irq_req, go,
      nonmaskable_pin_request, stop_mode, vbr_we, vbr_wdata} = '0;
    {imask_req, stop_capable} = '0;
    {imask_bit, xmask_bit} = 2'h3;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk(vec_addr, 16'hfffe);
    chk(16'(vector_base_register), 16'h00ff);
    t_ladder();
    t_hold();
    wk(8'h82, 16'hffea);
    wk(8'h12, 16'hff80);
    wk(8'h22, 16'hffea);
    wk(8'ha3, 16'hffea);
    wk(8'hfc, 16'hff80);
    wk(8'hdc, 16'hff80);
    wk(8'h84, 16'hfff4);
    print_verdict();
  end
endmodule
